/* File: core/mifd_decoder.sv */
`timescale 1ns/100ps
`include "mifd_defs.svh"
module mifd_decoder
	import mifd_pkg::*;
#(
	parameter int NUM_IN       = `MIFD_NUM_INPUTS,
	parameter int TEACH_CYCLES = `MIFD_TEACH_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic [NUM_IN-1:0] command_input,
	input  wire logic [2:0]        drive_mode,
	input  wire logic              bus_active,
	input  wire logic              cfg_wr_local,
	input  wire logic              cfg_wr_bus,
	input  wire logic [NUM_IN-1:0] cfg_pol_wdata,
	input  wire logic              limits_used,
	output logic [NUM_IN-1:0]      active_polarity,
	output logic                   cfg_rejected,
	output logic [4:0]             move_select,
	output logic                   move_start,
	output logic                   teach_store,
	output logic                   jog_negative,
	output logic                   jog_positive,
	output logic                   motor_enable,
	output logic                   limit_positive,
	output logic                   limit_negative,
	output logic                   motion_stop,
	output logic                   error_ack,
	output logic                   step_pulse,
	output logic                   step_direction,
	output logic [NUM_IN-1:0]      bus_gp_inputs
);
	localparam int CW = $clog2(TEACH_CYCLES + 1);

	typedef struct packed {
		logic [NUM_IN-1:0] pol;
		logic [NUM_IN-1:0] act_d;
		logic [CW-1:0]     hold_cnt;
		logic              taught;
		logic              rej;
		logic [4:0]        sel;
		logic              start;
		logic              teach;
		logic              jneg;
		logic              jpos;
		logic              en;
		logic              lpos;
		logic              lneg;
		logic              stop;
		logic              ack;
		logic              step;
		logic              dir;
		logic [NUM_IN-1:0] gp;
	} mifd_st_t;

	mifd_st_t          st_reg;
	mifd_st_t          st_next;
	logic [NUM_IN-1:0] in_sync;
	logic [NUM_IN-1:0] act;
	mifd_mode_t        mode;

	// RL17 pins synchronised first.
	mifd_sync #(
		.WIDTH (NUM_IN)
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    (command_input),
		.q    (in_sync)
	);

	assign mode = mifd_mode_t'(drive_mode);

	// RL1 per input polarity.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_pol
			assign act[gi] = st_reg.pol[gi] ? in_sync[gi] : ~in_sync[gi];
		end
	endgenerate

	always_comb begin
		logic is_bin;
		logic is_jog;
		logic is_pul;
		logic is_bus;
		logic rise6;
		logic fall6;
		logic stop_on;
		is_bin  = (mode == MIFD_MODE_BINARY);
		is_jog  = (mode == MIFD_MODE_JOG);
		is_pul  = (mode == MIFD_MODE_PULSE);
		is_bus  = (mode == MIFD_MODE_CAN) || (mode == MIFD_MODE_MBUS);
		rise6   = act[`MIFD_IN_START] & ~st_reg.act_d[`MIFD_IN_START];
		fall6   = ~act[`MIFD_IN_START] & st_reg.act_d[`MIFD_IN_START];
		stop_on = act[`MIFD_IN_STOP];
		st_next       = st_reg;
		st_next.act_d = act;
		st_next.rej   = 1'b0;
		// RL16 only dominant bus writes when active.
		if (bus_active) begin
			if (cfg_wr_bus) begin
				st_next.pol = cfg_pol_wdata;
			end
			st_next.rej = cfg_wr_local;
		end else if (cfg_wr_local) begin
			st_next.pol = cfg_pol_wdata;
		end
		st_next.start = 1'b0;
		st_next.teach = 1'b0;
		st_next.jneg  = 1'b0;
		st_next.jpos  = 1'b0;
		st_next.step  = 1'b0;
		st_next.dir   = 1'b0;
		st_next.stop  = 1'b0;
		st_next.ack   = 1'b0;
		st_next.sel   = 5'h00;
		st_next.gp    = '0;
		// RL8 enable in every mode.
		st_next.en = act[`MIFD_IN_ENABLE];
		// RL9 limit switches.
		st_next.lpos = act[`MIFD_IN_LIMPOS];
		st_next.lneg = act[`MIFD_IN_LIMNEG];
		if (!(is_jog && act[`MIFD_IN_START]) || stop_on) begin
			st_next.hold_cnt = '0;
			st_next.taught   = 1'b0;
		end
		// RL2 mode dependent mapping.
		if (is_bin) begin
			// RL3 five bit selection.
			st_next.sel = act[4:0];
			// RL10 stop and acknowledge.
			st_next.stop = stop_on;
			st_next.ack  = stop_on;
			// RL4 rising edge launch, RL11 stop dominant.
			st_next.start = rise6 & ~stop_on;
		end else if (is_jog) begin
			// RL3 three bit selection.
			st_next.sel  = {2'b00, act[2:0]};
			st_next.stop = stop_on;
			st_next.ack  = stop_on;
			// RL7 jog while held, RL11 stop dominant.
			st_next.jneg = act[3] & ~stop_on;
			st_next.jpos = act[4] & ~stop_on;
			// RL5 falling edge start unless a teach happened.
			st_next.start = fall6 & ~stop_on & ~st_reg.taught;
			// RL6 five second hold stores target.
			if (act[`MIFD_IN_START] && !stop_on && !st_reg.taught) begin
				if (st_reg.hold_cnt == CW'(TEACH_CYCLES - 1)) begin
					st_next.teach  = 1'b1;
					st_next.taught = 1'b1;
				end else begin
					st_next.hold_cnt = st_reg.hold_cnt + CW'(1);
				end
			end
		end else if (is_pul) begin
			// RL12 step and direction.
			st_next.step = act[0];
			st_next.dir  = act[1];
			// RL10 acknowledge only.
			st_next.ack = stop_on;
		end else if (is_bus) begin
			// RL13 pass through to bus master, RL14 keeps 7 to 9.
			st_next.gp[5:0]          = act[5:0];
			st_next.gp[`MIFD_IN_STOP] = stop_on;
			// RL15 free limits also passed through.
			if (!limits_used) begin
				st_next.gp[`MIFD_IN_LIMPOS] = act[`MIFD_IN_LIMPOS];
				st_next.gp[`MIFD_IN_LIMNEG] = act[`MIFD_IN_LIMNEG];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg     <= '0;
			st_reg.pol <= NUM_IN'(`MIFD_POL_RESET);
		end else begin
			st_reg <= st_next;
		end
	end

	assign active_polarity = st_reg.pol;
	assign cfg_rejected    = st_reg.rej;
	assign move_select     = st_reg.sel;
	assign move_start      = st_reg.start;
	assign teach_store     = st_reg.teach;
	assign jog_negative    = st_reg.jneg;
	assign jog_positive    = st_reg.jpos;
	assign motor_enable    = st_reg.en;
	assign limit_positive  = st_reg.lpos;
	assign limit_negative  = st_reg.lneg;
	assign motion_stop     = st_reg.stop;
	assign error_ack       = st_reg.ack;
	assign step_pulse      = st_reg.step;
	assign step_direction  = st_reg.dir;
	assign bus_gp_inputs   = st_reg.gp;

	chk_stop_blocks_start: assert property (@(posedge clk) disable iff (srst) // RL11
		(motion_stop |-> !move_start && !jog_negative && !jog_positive))
		else $error("Movement issued while stop asserted.");
	chk_binary_rise_start: assert property (@(posedge clk) disable iff (srst) // RL4
		(mode == MIFD_MODE_BINARY && $rose(act[`MIFD_IN_START]) && !act[`MIFD_IN_STOP]
		&& $stable(drive_mode) |=> move_start))
		else $error("Binary start missed on rising edge.");
	chk_jog_fall_start: assert property (@(posedge clk) disable iff (srst) // RL5
		(move_start && $past(mode) == MIFD_MODE_JOG |-> $past(act[`MIFD_IN_START], 2)
		&& !$past(act[`MIFD_IN_START])))
		else $error("Jog start not on falling edge.");
	chk_enable_follows: assert property (@(posedge clk) disable iff (srst) // RL8
		(##1 motor_enable == $past(act[`MIFD_IN_ENABLE])))
		else $error("Enable does not follow input seven.");
	chk_limits_follow: assert property (@(posedge clk) disable iff (srst) // RL9
		(##1 limit_positive == $past(act[`MIFD_IN_LIMPOS]) && limit_negative == $past(act[`MIFD_IN_LIMNEG])))
		else $error("Limit outputs do not follow inputs.");
	chk_pulse_no_stop: assert property (@(posedge clk) disable iff (srst) // RL10
		($past(mode) == MIFD_MODE_PULSE |-> !motion_stop && error_ack == $past(act[`MIFD_IN_STOP])))
		else $error("Pulse mode stop or acknowledge wrong.");
	chk_local_reject: assert property (@(posedge clk) disable iff (srst) // RL16
		(bus_active && cfg_wr_local && !cfg_wr_bus |=> cfg_rejected && $stable(active_polarity)))
		else $error("Local configuration accepted while bus active.");
	chk_bus_gp_mask: assert property (@(posedge clk) disable iff (srst) // RL13
		($past(mode) != MIFD_MODE_CAN && $past(mode) != MIFD_MODE_MBUS |-> bus_gp_inputs == '0))
		else $error("General purpose inputs leak outside bus modes.");
	chk_teach_needs_hold: assert property (@(posedge clk) disable iff (srst) // RL6
		(teach_store |-> $past(act[`MIFD_IN_START]) && $past(act[`MIFD_IN_START], 2)))
		else $error("Teach stored without continuous hold.");

	chk_binary_select: assert property (@(posedge clk) disable iff (srst) // RL3
		($past(mode) == MIFD_MODE_BINARY |-> move_select == $past(act[4:0])))
		else $error("Binary selection does not follow inputs one to five.");

	chk_jog_select: assert property (@(posedge clk) disable iff (srst) // RL3
		($past(mode) == MIFD_MODE_JOG |-> move_select == {2'b00, $past(act[2:0])}))
		else $error("Jog selection does not follow inputs one to three.");

	chk_select_idle: assert property (@(posedge clk) disable iff (srst) // RL2
		($past(mode) != MIFD_MODE_BINARY && $past(mode) != MIFD_MODE_JOG |-> move_select == 5'h00))
		else $error("Selection driven outside binary and jog modes.");

	chk_jog_negative: assert property (@(posedge clk) disable iff (srst) // RL7
		($past(mode) == MIFD_MODE_JOG
		|-> jog_negative == ($past(act[3]) && !$past(act[`MIFD_IN_STOP]))))
		else $error("Negative jog does not follow input four.");

	chk_jog_positive: assert property (@(posedge clk) disable iff (srst) // RL7
		($past(mode) == MIFD_MODE_JOG
		|-> jog_positive == ($past(act[4]) && !$past(act[`MIFD_IN_STOP]))))
		else $error("Positive jog does not follow input five.");

	chk_jog_idle: assert property (@(posedge clk) disable iff (srst) // RL7
		($past(mode) != MIFD_MODE_JOG |-> !jog_negative && !jog_positive))
		else $error("Jog driven outside jog mode.");

	chk_step_follow: assert property (@(posedge clk) disable iff (srst) // RL12
		($past(mode) == MIFD_MODE_PULSE
		|-> step_pulse == $past(act[0]) && step_direction == $past(act[1])))
		else $error("Step or direction does not follow inputs one and two.");

	chk_step_idle: assert property (@(posedge clk) disable iff (srst) // RL12
		($past(mode) != MIFD_MODE_PULSE |-> !step_pulse && !step_direction))
		else $error("Step or direction driven outside pulse mode.");

	chk_stop_ack_level: assert property (@(posedge clk) disable iff (srst) // RL10
		($past(mode) == MIFD_MODE_BINARY || $past(mode) == MIFD_MODE_JOG
		|-> motion_stop == $past(act[`MIFD_IN_STOP]) && error_ack == $past(act[`MIFD_IN_STOP])))
		else $error("Stop or acknowledge does not follow input ten.");

	chk_stop_idle: assert property (@(posedge clk) disable iff (srst) // RL10
		($past(mode) != MIFD_MODE_BINARY && $past(mode) != MIFD_MODE_JOG && $past(mode) != MIFD_MODE_PULSE
		|-> !motion_stop && !error_ack))
		else $error("Stop or acknowledge driven in a bus or idle mode.");

	chk_bus_gp_pass: assert property (@(posedge clk) disable iff (srst) // RL13
		($past(mode) == MIFD_MODE_CAN || $past(mode) == MIFD_MODE_MBUS
		|-> bus_gp_inputs[5:0] == $past(act[5:0]) && bus_gp_inputs[9] == $past(act[`MIFD_IN_STOP])
		&& !bus_gp_inputs[6]))
		else $error("Bus inputs do not follow command inputs.");

	chk_bus_free_limits: assert property (@(posedge clk) disable iff (srst) // RL15
		(($past(mode) == MIFD_MODE_CAN || $past(mode) == MIFD_MODE_MBUS) && !$past(limits_used)
		|-> bus_gp_inputs[8:7] == $past(act[8:7])))
		else $error("Free limit inputs not passed to the bus.");

	chk_bus_used_limits: assert property (@(posedge clk) disable iff (srst) // RL14
		(($past(mode) == MIFD_MODE_CAN || $past(mode) == MIFD_MODE_MBUS) && $past(limits_used)
		|-> bus_gp_inputs[8:7] == 2'b00 && limit_positive == $past(act[`MIFD_IN_LIMPOS])
		&& limit_negative == $past(act[`MIFD_IN_LIMNEG])))
		else $error("Limit functions lost in bus mode.");

	chk_bus_write: assert property (@(posedge clk) disable iff (srst) // RL16
		(bus_active && cfg_wr_bus |=> active_polarity == $past(cfg_pol_wdata)))
		else $error("Bus configuration write not applied.");

	chk_local_write: assert property (@(posedge clk) disable iff (srst) // RL16
		(!bus_active && cfg_wr_local |=> active_polarity == $past(cfg_pol_wdata) && !cfg_rejected))
		else $error("Local configuration write not applied.");

	chk_idle_bus_write: assert property (@(posedge clk) disable iff (srst) // RL16
		(!bus_active && cfg_wr_bus && !cfg_wr_local |=> $stable(active_polarity)))
		else $error("Bus write applied while no bus is active.");

	chk_pol_steady: assert property (@(posedge clk) disable iff (srst) // RL1
		(!cfg_wr_local && !cfg_wr_bus |=> $stable(active_polarity)))
		else $error("Polarity changed without a write.");

	chk_reject_cause: assert property (@(posedge clk) disable iff (srst) // RL16
		(cfg_rejected |-> $past(bus_active) && $past(cfg_wr_local)))
		else $error("Rejection without a local write on an active bus.");

	chk_start_modes: assert property (@(posedge clk) disable iff (srst) // RL11
		(move_start |-> ($past(mode) == MIFD_MODE_BINARY || $past(mode) == MIFD_MODE_JOG)
		&& !$past(act[`MIFD_IN_STOP])))
		else $error("Start issued in a wrong mode or under stop.");

	chk_binary_edge: assert property (@(posedge clk) disable iff (srst) // RL4
		(move_start && $past(mode) == MIFD_MODE_BINARY
		|-> $past(act[`MIFD_IN_START]) && !$past(act[`MIFD_IN_START], 2)))
		else $error("Binary start without a rising edge.");

	chk_teach_mode: assert property (@(posedge clk) disable iff (srst) // RL6
		(teach_store |-> $past(mode) == MIFD_MODE_JOG && !$past(act[`MIFD_IN_STOP]) && !move_start))
		else $error("Teach stored outside jog mode or under stop.");
endmodule

/* File: core/mifd_defs.svh */
// Contract
// RL1 - Each input has a selectable active level, high or low.
// RL2 - Input functions follow the selected drive mode.
// RL3 - Binary: inputs one to five form selection; jog/teach: inputs one to three.
// RL4 - Binary: rising edge of input six launches the selected movement.
// RL5 - Jog/teach: falling edge of input six starts the selected movement.
// RL6 - Jog/teach: input six held five seconds stores teach target.
// RL7 - Jog/teach: input four jogs negative, input five jogs positive.
// RL8 - Input seven switches motor current on and off in every mode.
// RL9 - Input eight is positive limit, input nine negative limit.
// RL10 - Input ten stops and acknowledges; in pulse/direction only acknowledges.
// RL11 - Binary and jog/teach: asserted input ten blocks all movement.
// RL12 - Pulse/direction: input one steps, input two direction, three to six ignored.
// RL13 - Bus modes: inputs one to six and ten go to bus master.
// RL14 - Bus modes keep enable and limit switch functions.
// RL15 - Limits unused: inputs eight and nine also pass to bus master.
// RL16 - With bus active only the dominant bus may change configuration.
// RL17 - Every input passes two flip-flops before polarity or edge logic.
`ifndef MIFD_DEFS_SVH
`define MIFD_DEFS_SVH
`define MIFD_NUM_INPUTS 10
`define MIFD_POL_RESET 10'h3FF
`define MIFD_TEACH_TIME_S 5
`define MIFD_CLK_HZ 100000000
`define MIFD_TEACH_CYCLES (`MIFD_TEACH_TIME_S * `MIFD_CLK_HZ)
`define MIFD_IN_START 5
`define MIFD_IN_ENABLE 6
`define MIFD_IN_LIMPOS 7
`define MIFD_IN_LIMNEG 8
`define MIFD_IN_STOP 9
`endif

/* File: core/mifd_pkg.sv */
package mifd_pkg;
	typedef enum logic [2:0] {
		MIFD_MODE_NONE   = 3'b000,
		MIFD_MODE_BINARY = 3'b001,
		MIFD_MODE_JOG    = 3'b010,
		MIFD_MODE_PULSE  = 3'b011,
		MIFD_MODE_CAN    = 3'b100,
		MIFD_MODE_MBUS   = 3'b101
	} mifd_mode_t;
endpackage

/* File: core/mifd_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for the raw command inputs.
module mifd_sync #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} mifd_sync_st_t;

	mifd_sync_st_t st_reg;
	mifd_sync_st_t st_next;

	// RL17 two flop chain.
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule

/* File: test/mifd_far_model.sv */
`timescale 1ns/100ps
// Switches and controller: turn asserted states into pin levels.
module mifd_far_model (
	input  wire logic [9:0] asserted,
	input  wire logic [9:0] polarity,
	output logic      [9:0] pins
);
	assign pins = ~(asserted ^ polarity);
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	import mifd_pkg::*;
	logic        clk, srst, bus_active, cfg_wr_local, cfg_wr_bus, limits_used;
	logic        cfg_rejected, move_start, teach_store, jog_negative, jog_positive, motor_enable;
	logic        limit_positive, limit_negative, motion_stop, error_ack, step_pulse, step_direction;
	logic [2:0]  drive_mode;
	logic [4:0]  move_select;
	logic [9:0]  pins, act, pol, wdata, active_polarity, bus_gp_inputs;
	logic [23:0] lv;
	logic [31:0] seed;
	logic [7:0]  notes[$];
	int          fails, total_checks;

	assign lv = {move_select, jog_negative, jog_positive, motor_enable, limit_positive, limit_negative,
		motion_stop, error_ack, step_pulse, step_direction, bus_gp_inputs};

	mifd_far_model u_mifd_far_model (.asserted(act), .polarity(pol), .pins(pins));

	mifd_decoder #(.TEACH_CYCLES(20)) u_mifd_decoder (
		.clk, .srst, .command_input(pins), .drive_mode, .bus_active, .cfg_wr_local, .cfg_wr_bus,
		.cfg_pol_wdata(wdata), .limits_used, .active_polarity, .cfg_rejected, .move_select,
		.move_start, .teach_store, .jog_negative, .jog_positive, .motor_enable, .limit_positive,
		.limit_negative, .motion_stop, .error_ack, .step_pulse, .step_direction, .bus_gp_inputs
	);

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	task automatic check(logic [23:0] seen, logic [23:0] want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic void step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic pulse6(int n);
		act[5] = 1;
		cyc(n);
		act[5] = 0;
		cyc(6);
	endtask

	function automatic logic [23:0] expect_lv(logic [2:0] m, logic [9:0] a, logic lu);
		logic [4:0] sel;
		logic [3:0] jg;
		logic [1:0] st;
		logic [9:0] gp;
		sel = 5'h0;
		jg = 4'h0;
		st = 2'b00;
		gp = 10'h000;
		case (m)
			MIFD_MODE_BINARY: begin
				sel = a[4:0];
				jg = {2'b00, a[9], a[9]};
			end
			MIFD_MODE_JOG: begin
				sel = {2'b00, a[2:0]};
				jg = {a[3] & ~a[9], a[4] & ~a[9], a[9], a[9]};
			end
			MIFD_MODE_PULSE: begin
				jg = {3'b000, a[9]};
				st = {a[0], a[1]};
			end
			MIFD_MODE_CAN, MIFD_MODE_MBUS: gp = {a[9], lu ? 2'b00 : a[8:7], 1'b0, a[5:0]};
			default: gp = 10'h000;
		endcase
		return {sel, jg[3:2], a[6], a[7], a[8], jg[1:0], st, gp};
	endfunction

	// Each pulse takes the oldest note and is compared with it.
	always @(negedge clk) begin
		if ((move_start | teach_store | cfg_rejected) === 1'b1) begin
			if (notes.size() == 0)
				check({16'h0, move_start, teach_store, cfg_rejected, 5'h0}, 24'h0);
			else
				check({16'h0, move_start, teach_store, cfg_rejected, move_select}, {16'h0, notes.pop_front()});
		end
	end

	initial begin
		#300000;
		fails++;
		final_report();
	end

	initial begin
		seed = 32'h0000_5163;
		fails = 0;
		total_checks = 0;
		srst = 1;
		bus_active = 0;
		cfg_wr_local = 0;
		cfg_wr_bus = 0;
		limits_used = 1;
		drive_mode = MIFD_MODE_PULSE;
		act = 10'h000;
		pol = 10'h3FF;
		wdata = 10'h3FF;
		cyc(2);
		srst = 0;
		check({14'h0, active_polarity}, 24'h00_03FF);
		step();
		wdata = seed[9:0];
		cfg_wr_local = 1;
		cyc(1);
		cfg_wr_local = 0;
		pol = wdata;
		check({14'h0, active_polarity}, {14'h0, wdata});
		cyc(4);
		for (int m = 0; m < 6; m++) begin
			drive_mode = m[2:0];
			repeat (6) begin
				step();
				act = seed[9:0];
				if (m < 3)
					act[5] = 0;
				limits_used = seed[12];
				cyc(4);
				check(lv, expect_lv(drive_mode, act, limits_used));
			end
		end
		act = 10'h000;
		cyc(4);
		drive_mode = MIFD_MODE_BINARY;
		step();
		act[4:0] = seed[4:0];
		act[6] = 1;
		cyc(4);
		notes.push_back({3'b100, seed[4:0]});
		pulse6(5);
		act[9] = 1;
		pulse6(5);
		act[9] = 0;
		drive_mode = MIFD_MODE_JOG;
		cyc(4);
		notes.push_back({3'b100, 2'b00, act[2:0]});
		pulse6(5);
		notes.push_back({3'b010, 2'b00, act[2:0]});
		pulse6(40);
		notes.push_back({3'b100, 2'b00, act[2:0]});
		pulse6(19);
		notes.push_back({3'b010, 2'b00, act[2:0]});
		pulse6(20);
		act[9] = 1;
		pulse6(40);
		act[9] = 0;
		drive_mode = MIFD_MODE_PULSE;
		bus_active = 1;
		cyc(4);
		notes.push_back(8'h20);
		wdata = ~pol;
		cfg_wr_local = 1;
		cyc(1);
		cfg_wr_local = 0;
		check({14'h0, active_polarity}, {14'h0, pol});
		cfg_wr_bus = 1;
		cyc(1);
		cfg_wr_bus = 0;
		pol = wdata;
		check({14'h0, active_polarity}, {14'h0, wdata});
		srst = 1;
		pol = 10'h3FF;
		cyc(2);
		srst = 0;
		check({14'h0, active_polarity}, 24'h00_03FF);
		check(lv, 24'h00_0000);
		cyc(4);
		check(lv, expect_lv(drive_mode, act, limits_used));
		for (int i = 0; i < 50 && notes.size() > 0; i++)
			cyc(1);
		if (notes.size() > 0)
			fails++;
		final_report();
	end
endmodule
